// [design/time_conv_defines.svh]
// Purpose: offsets, field positions, reset values of the converter register map
// Assumes: 4-bit register address, 28-bit register word
// Notes: header of constants only
// How it works
// - 18-bit primary start offset in bits 0-17 of register 5, used in every mode.
// - Secondary start offset in register 6 bits 8-25 applies in G-Mode only.
// - Register 5 bit 21 keeps stop inputs disabled until a start has arrived.
// - Register 5 bit 22 ignores further starts after one, in G, R, M modes.
// - Register 5 bit 23: trigger pin high gives master reset, quiet off only.
// - Register 5 bit 24: trigger pin high gives partial reset, quiet off only.
// - Register 5 bit 25: output-enable pin low gives master reset.
// - Register 5 bit 26: output-enable pin low gives partial reset.
// - Fill flags of both result queues set when occupancy reaches register 6 bits 0-7.
// - Reading register 6 returns the fill threshold bits inverted.
// - I-Mode with register 6 bit 26: stop input one to odd, two to even channels.
// - Differential input buffers powered only while register 6 bit 27 is one.
// - PLL fast divider in register 7 bits 0-7, reference divider in bits 8-10.
// - Register 7 bit 11 tuning on, bit 12 phase invert, bit 13 opens loop.
// - Internal timer runs 1 to 8192 reference periods (value plus one) from register 7 bits 15-27.
// - Register 14 bit 4 selects 16-bit bus; other bits are written zero.
// - In 16-bit mode every register access is two consecutive 16-bit transfers.
// - I-Mode result: time 0-16, slope 17, start number 18-25, channel 26-27.
// - G-Mode result: time 0-21, slope in bit 22, one means rising.
// - R and M mode result: time in bits 0-22 only, upper bits zero.
// - Register 10 returns first-start interval bits 0-16 in I-Mode, else zero.
// - Master reset clears state but not config; partial also keeps queue content.
// - Quiet mode: ALU starts only on trigger pin rising edge or software trigger.
`ifndef TIME_CONV_DEFINES_SVH
`define TIME_CONV_DEFINES_SVH
`define WORD_W          28
`define HALF_W          16
`define ADR_GATING      4'h5
`define ADR_LEVEL       4'h6
`define ADR_PLL         4'h7
`define ADR_RESULT_A    4'h8
`define ADR_RESULT_B    4'h9
`define ADR_INTERVAL    4'hA
`define ADR_BUS_WIDTH   4'hE
`define CFG_RESET       28'h0000000
`define OFS1_MSB        17
`define OFS1_LSB        0
`define GATE_STOP_BIT   21
`define GATE_START_BIT  22
`define FULL_TRIG_BIT   23
`define PART_TRIG_BIT   24
`define FULL_OEN_BIT    25
`define PART_OEN_BIT    26
`define FILL_MSB        7
`define FILL_LSB        0
`define OFS2_MSB        25
`define OFS2_LSB        8
`define ROUTE_BIT       26
`define POWER_BIT       27
`define FAST_DIV_MSB    7
`define FAST_DIV_LSB    0
`define REF_DIV_MSB     10
`define REF_DIV_LSB     8
`define TUNE_BIT        11
`define PHASE_BIT       12
`define LOOP_OPEN_BIT   13
`define TIMER_MSB       27
`define TIMER_LSB       15
`define HALF_BUS_BIT    4
`define HALF_BUS_MASK   28'h0000010
`define QUEUE_DEPTH     2
`endif

// [design/time_conv_pkg.sv]
// Purpose: shared types of the converter register map
// Assumes: nothing
// Notes: constants live in the defines header
`default_nettype none
package time_conv_pkg;
  typedef enum logic [1:0] {MODE_I, MODE_G, MODE_R, MODE_M} mode_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD, BUS_WR} bus_state_t;
  typedef struct packed {
    logic [1:0]  chan_tag;
    logic [7:0]  start_num;
    logic        slope;
    logic [22:0] hit_time;
  } hit_t;
endpackage
`default_nettype wire

// [design/result_queue_if.sv]
// Purpose: carrier between the register bank and one result buffer
// Assumes: single clock
// Notes: owner side feeds and drains, buffer side stores
`timescale 1ns/10ps
`default_nettype none
interface result_queue_if #(parameter int W = 34, parameter int LW = 2);
  logic          push_valid;
  logic          push_ready;
  logic [W-1:0]  push_data;
  logic          pop_valid;
  logic          pop_ready;
  logic [W-1:0]  pop_data;
  logic [LW-1:0] level;
  logic          flush;
  modport buffer (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data, level);
  modport owner (output push_valid, push_data, pop_ready, flush,
                 input push_ready, pop_valid, pop_data, level);
endinterface
`default_nettype wire

// [design/result_buffer.sv]
// Purpose: small result queue with valid/ready on both sides
// Assumes: level width of the carrier is clog2(DEPTH+1)
// Notes: flush empties it; a full queue stalls the producer
`timescale 1ns/10ps
`default_nettype none
module result_buffer #(
  parameter int W     = 34,
  parameter int DEPTH = 2
) (
  input wire logic        clk,
  input wire logic        rst,
  result_queue_if.buffer  q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [LW-1:0] count_reg;
  logic          do_push;
  logic          do_pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign q.push_ready = (count_reg != LW'(DEPTH));
  assign q.pop_valid  = (count_reg != '0);
  assign q.pop_data   = mem_reg[rd_ptr_reg];
  assign q.level      = count_reg;
  assign do_push      = q.push_valid && q.push_ready;
  assign do_pop       = q.pop_ready && q.pop_valid;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= q.push_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (q.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (do_pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      case ({do_push, do_pop})
        2'b10:   count_reg <= LW'(count_reg + 1'b1);
        2'b01:   count_reg <= LW'(count_reg - 1'b1);
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

// [design/time_conv_regs.sv]
// Purpose: configuration and result register bank of the time converter
// Assumes: asynchronous strobed parallel bus, measurement core on CLK
// Notes: all pins except CLK and RESET pass two flip-flops; writes commit when the write strobe ends
`include "time_conv_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module time_conv_regs #(
  parameter int DEPTH = `QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  // register bus pins
  input  wire logic                    CS_N,
  input  wire logic                    RD_N,
  input  wire logic                    WR_N,
  input  wire logic [3:0]              ADDR,
  input  wire logic [`WORD_W-1:0]      DATA_IN,
  output logic      [`WORD_W-1:0]      DATA_OUT,
  output logic                         DATA_OE,
  input  wire logic                    OUTPUT_ENABLE_PIN_N,
  // trigger and start pins
  input  wire logic                    ALU_TRIGGER,
  input  wire logic                    START_PIN,
  // status from the measurement core
  input  wire logic [1:0]              MODE,
  input  wire logic                    QUIET,
  input  wire logic                    SOFT_TRIGGER,
  input  wire logic                    REF_TICK,
  input  wire logic                    TIMER_START,
  input  wire logic [16:0]             START_INTERVAL,
  // result streams from the core
  input  wire logic                    RESULT_A_VALID,
  output logic                         RESULT_A_READY,
  input  wire time_conv_pkg::hit_t     RESULT_A_DATA,
  input  wire logic                    RESULT_B_VALID,
  output logic                         RESULT_B_READY,
  input  wire time_conv_pkg::hit_t     RESULT_B_DATA,
  // controls to the core
  output logic [17:0]                  START_OFFSET_PRIMARY,
  output logic [17:0]                  START_OFFSET_SECONDARY,
  output logic                         STOP_INPUTS_ENABLE,
  output logic                         START_INPUT_ENABLE,
  output logic                         FULL_RESET,
  output logic                         PART_RESET,
  output logic [1:0]                   FILL_FLAG,
  output logic                         DIFF_ROUTING,
  output logic                         DIFF_POWER,
  output logic [7:0]                   PLL_FAST_DIV,
  output logic [2:0]                   PLL_REF_DIV,
  output logic                         RES_TUNE_ON,
  output logic                         PLL_PHASE_INVERT,
  output logic                         PLL_LOOP_OPEN,
  output logic                         TIMER_END,
  output logic                         ALU_START,
  output logic                         ALU_AUTO
);
  localparam int LW = $clog2(DEPTH + 1);
  localparam int HW = $bits(time_conv_pkg::hit_t);

  time_conv_pkg::mode_t      mode;
  time_conv_pkg::bus_state_t state_reg;
  logic [`WORD_W-1:0] cfg5_reg, cfg6_reg, cfg7_reg, cfg14_reg;
  logic [`WORD_W-1:0] word_reg, wdata_reg, read_mux, commit_word;
  logic [`HALF_W-1:0] low_half_reg;
  logic [3:0]         waddr_reg;
  logic               half_reg;
  logic               half_bus;
  // pin synchronisers: first stage feeds the second only
  logic [1:0]         cs_sync_reg, rd_sync_reg, wr_sync_reg;
  logic [1:0]         oen_sync_reg, trig_sync_reg, start_sync_reg;
  logic [3:0]         addr_meta_reg, addr_sync_reg;
  logic [`WORD_W-1:0] data_meta_reg, data_sync_reg;
  logic               trig_prev_reg, start_prev_reg;
  logic               start_seen_reg;
  logic               timer_run_reg;
  logic [12:0]        timer_cnt_reg;
  logic               rd_act, wr_act, trig_s, oen_low, start_rise, trig_rise;
  logic               full_next, part_next, oen_repurposed;
  logic               pop_a, pop_b;

  result_queue_if #(.W(HW), .LW(LW)) qa ();
  result_queue_if #(.W(HW), .LW(LW)) qb ();

  result_buffer #(.W(HW), .DEPTH(DEPTH)) u_queue_a (
    .clk (CLK),
    .rst (RESET),
    .q   (qa)
  );
  result_buffer #(.W(HW), .DEPTH(DEPTH)) u_queue_b (
    .clk (CLK),
    .rst (RESET),
    .q   (qb)
  );

  // result word layout depends on the measurement mode
  function automatic logic [`WORD_W-1:0] fmt(input time_conv_pkg::hit_t h,
                                             input time_conv_pkg::mode_t m);
    case (m)
      time_conv_pkg::MODE_I: fmt = {h.chan_tag, h.start_num, h.slope,
                                    h.hit_time[16:0]};
      time_conv_pkg::MODE_G: fmt = {5'h00, h.slope, h.hit_time[21:0]};
      default:               fmt = {5'h00, h.hit_time};
    endcase
  endfunction

  function automatic logic fill_hit(input logic [7:0] lvl, input logic [7:0] thr);
    fill_hit = (lvl >= thr);
  endfunction

  assign mode     = time_conv_pkg::mode_t'(MODE);
  assign half_bus = cfg14_reg[`HALF_BUS_BIT];

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cs_sync_reg    <= 2'h3;
      rd_sync_reg    <= 2'h3;
      wr_sync_reg    <= 2'h3;
      oen_sync_reg   <= 2'h3;
      trig_sync_reg  <= 2'h0;
      start_sync_reg <= 2'h0;
      addr_meta_reg  <= 4'h0;
      addr_sync_reg  <= 4'h0;
      data_meta_reg  <= 28'h0000000;
      data_sync_reg  <= 28'h0000000;
      trig_prev_reg  <= 1'b0;
      start_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg    <= {cs_sync_reg[0], CS_N};
      rd_sync_reg    <= {rd_sync_reg[0], RD_N};
      wr_sync_reg    <= {wr_sync_reg[0], WR_N};
      oen_sync_reg   <= {oen_sync_reg[0], OUTPUT_ENABLE_PIN_N};
      trig_sync_reg  <= {trig_sync_reg[0], ALU_TRIGGER};
      start_sync_reg <= {start_sync_reg[0], START_PIN};
      addr_meta_reg  <= ADDR;
      addr_sync_reg  <= addr_meta_reg;
      data_meta_reg  <= DATA_IN;
      data_sync_reg  <= data_meta_reg;
      trig_prev_reg  <= trig_sync_reg[1];
      start_prev_reg <= start_sync_reg[1];
    end
  end

  assign rd_act     = !cs_sync_reg[1] && !rd_sync_reg[1];
  assign wr_act     = !cs_sync_reg[1] && !wr_sync_reg[1];
  assign trig_s     = trig_sync_reg[1];
  assign oen_low    = !oen_sync_reg[1];
  assign trig_rise  = trig_s && !trig_prev_reg;
  assign start_rise = start_sync_reg[1] && !start_prev_reg;

  // reset requests follow the pin level, so they hold as long as the pin does
  assign full_next = (!QUIET && cfg5_reg[`FULL_TRIG_BIT] && trig_s)
                   || (cfg5_reg[`FULL_OEN_BIT] && oen_low);
  assign part_next = (!QUIET && cfg5_reg[`PART_TRIG_BIT] && trig_s)
                   || (cfg5_reg[`PART_OEN_BIT] && oen_low);
  assign oen_repurposed = cfg5_reg[`FULL_OEN_BIT] || cfg5_reg[`PART_OEN_BIT];

  always_comb begin
    case (addr_sync_reg)
      `ADR_GATING:    read_mux = cfg5_reg;
      `ADR_LEVEL:     read_mux = {cfg6_reg[`WORD_W-1:`FILL_MSB+1],
                                  ~cfg6_reg[`FILL_MSB:`FILL_LSB]};
      `ADR_PLL:       read_mux = cfg7_reg;
      `ADR_RESULT_A:  read_mux = qa.pop_valid ? fmt(qa.pop_data, mode) : '0;
      `ADR_RESULT_B:  read_mux = qb.pop_valid ? fmt(qb.pop_data, mode) : '0;
      `ADR_INTERVAL:  read_mux = (mode == time_conv_pkg::MODE_I) ?
                                 {11'h000, START_INTERVAL} : '0;
      `ADR_BUS_WIDTH: read_mux = cfg14_reg;
      default:        read_mux = '0;
    endcase
  end

  // a 16-bit pair carries the low half first, then the upper twelve bits
  assign commit_word = half_bus ? {wdata_reg[11:0], low_half_reg} : wdata_reg;

  // bus sequencer: reads latch at strobe start, writes commit at strobe end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg    <= time_conv_pkg::BUS_IDLE;
      word_reg     <= 28'h0000000;
      DATA_OUT     <= 28'h0000000;
      wdata_reg    <= 28'h0000000;
      waddr_reg    <= 4'h0;
      low_half_reg <= 16'h0000;
      half_reg     <= 1'b0;
    end else begin
      case (state_reg)
        time_conv_pkg::BUS_IDLE: begin
          if (!half_bus) begin
            half_reg <= 1'b0;
          end
          if (rd_act) begin
            state_reg <= time_conv_pkg::BUS_RD;
            if (half_bus && half_reg) begin
              DATA_OUT <= {16'h0000, word_reg[`WORD_W-1:`HALF_W]};
            end else begin
              word_reg <= read_mux;
              DATA_OUT <= half_bus ? {12'h000, read_mux[`HALF_W-1:0]} : read_mux;
            end
          end else if (wr_act) begin
            state_reg <= time_conv_pkg::BUS_WR;
          end
        end
        time_conv_pkg::BUS_RD: begin
          if (!rd_act) begin
            state_reg <= time_conv_pkg::BUS_IDLE;
            if (half_bus) begin
              half_reg <= !half_reg;
            end
          end
        end
        time_conv_pkg::BUS_WR: begin
          if (wr_act) begin
            wdata_reg <= data_sync_reg;
            waddr_reg <= addr_sync_reg;
          end else begin
            state_reg <= time_conv_pkg::BUS_IDLE;
            if (half_bus) begin
              half_reg <= !half_reg;
              if (!half_reg) begin
                low_half_reg <= wdata_reg[`HALF_W-1:0];
              end
            end
          end
        end
        default: state_reg <= time_conv_pkg::BUS_IDLE;
      endcase
    end
  end

  // configuration survives master and partial resets; only RESET clears it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cfg5_reg  <= `CFG_RESET;
      cfg6_reg  <= `CFG_RESET;
      cfg7_reg  <= `CFG_RESET;
      cfg14_reg <= `CFG_RESET;
    end else if (state_reg == time_conv_pkg::BUS_WR && !wr_act
                 && (!half_bus || half_reg)) begin
      case (waddr_reg)
        `ADR_GATING:    cfg5_reg  <= commit_word;
        `ADR_LEVEL:     cfg6_reg  <= commit_word;
        `ADR_PLL:       cfg7_reg  <= commit_word;
        `ADR_BUS_WIDTH: cfg14_reg <= commit_word & `HALF_BUS_MASK;
        default:        cfg5_reg  <= cfg5_reg;
      endcase
    end
  end

  // a result leaves its queue when the read strobe of its word, or of its low half on a 16-bit bus, ends
  assign pop_a = state_reg == time_conv_pkg::BUS_RD && !rd_act
               && addr_sync_reg == `ADR_RESULT_A && (!half_bus || !half_reg);
  assign pop_b = state_reg == time_conv_pkg::BUS_RD && !rd_act
               && addr_sync_reg == `ADR_RESULT_B && (!half_bus || !half_reg);

  assign qa.push_valid   = RESULT_A_VALID;
  assign qa.push_data    = RESULT_A_DATA;
  assign qa.pop_ready    = pop_a;
  assign qa.flush        = FULL_RESET;
  assign RESULT_A_READY  = qa.push_ready;
  assign qb.push_valid   = RESULT_B_VALID;
  assign qb.push_data    = RESULT_B_DATA;
  assign qb.pop_ready    = pop_b;
  assign qb.flush        = FULL_RESET;

  assign RESULT_B_READY  = qb.push_ready;
  // pin is only an output enable while it is not assigned to resets
  assign DATA_OE = (state_reg == time_conv_pkg::BUS_RD) && (oen_repurposed || oen_low);

  // start gating state; either reset kind forgets the accepted start
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      start_seen_reg <= 1'b0;
    end else if (FULL_RESET || PART_RESET) begin
      start_seen_reg <= 1'b0;
    end else if (start_rise && START_INPUT_ENABLE) begin
      start_seen_reg <= 1'b1;
    end
  end

  // internal timer counts reference periods from the programmed length
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      timer_run_reg <= 1'b0;
      timer_cnt_reg <= 13'h0000;
      TIMER_END     <= 1'b0;
    end else if (FULL_RESET || PART_RESET) begin
      timer_run_reg <= 1'b0;
      timer_cnt_reg <= 13'h0000;
      TIMER_END     <= 1'b0;
    end else begin
      TIMER_END <= 1'b0;
      if (TIMER_START) begin
        timer_run_reg <= 1'b1;
        timer_cnt_reg <= cfg7_reg[`TIMER_MSB:`TIMER_LSB];
      end else if (timer_run_reg && REF_TICK) begin
        if (timer_cnt_reg == 13'h0000) begin
          timer_run_reg <= 1'b0;
          TIMER_END     <= 1'b1;
        end else begin
          timer_cnt_reg <= timer_cnt_reg - 13'h0001;
        end
      end
    end
  end

  // registered controls towards the core
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      FULL_RESET             <= 1'b0;
      PART_RESET             <= 1'b0;
      START_OFFSET_PRIMARY   <= 18'h00000;
      START_OFFSET_SECONDARY <= 18'h00000;
      STOP_INPUTS_ENABLE     <= 1'b0;
      START_INPUT_ENABLE     <= 1'b0;
      FILL_FLAG              <= 2'h0;
      DIFF_ROUTING           <= 1'b0;
      DIFF_POWER             <= 1'b0;
      PLL_FAST_DIV           <= 8'h00;
      PLL_REF_DIV            <= 3'h0;
      RES_TUNE_ON            <= 1'b0;
      PLL_PHASE_INVERT       <= 1'b0;
      PLL_LOOP_OPEN          <= 1'b0;
      ALU_START              <= 1'b0;
      ALU_AUTO               <= 1'b0;
    end else begin
      FULL_RESET           <= full_next;
      PART_RESET           <= part_next;
      START_OFFSET_PRIMARY <= cfg5_reg[`OFS1_MSB:`OFS1_LSB];
      START_OFFSET_SECONDARY <= (mode == time_conv_pkg::MODE_G) ?
                                cfg6_reg[`OFS2_MSB:`OFS2_LSB] : 18'h00000;
      STOP_INPUTS_ENABLE   <= !cfg5_reg[`GATE_STOP_BIT] || start_seen_reg;
      START_INPUT_ENABLE   <= !(cfg5_reg[`GATE_START_BIT] && start_seen_reg
                                && mode != time_conv_pkg::MODE_I);
      FILL_FLAG[0]         <= fill_hit(8'(qa.level), cfg6_reg[`FILL_MSB:`FILL_LSB]);
      FILL_FLAG[1]         <= fill_hit(8'(qb.level), cfg6_reg[`FILL_MSB:`FILL_LSB]);
      DIFF_ROUTING         <= cfg6_reg[`ROUTE_BIT]
                              && mode == time_conv_pkg::MODE_I;
      DIFF_POWER           <= cfg6_reg[`POWER_BIT];
      PLL_FAST_DIV         <= cfg7_reg[`FAST_DIV_MSB:`FAST_DIV_LSB];
      PLL_REF_DIV          <= cfg7_reg[`REF_DIV_MSB:`REF_DIV_LSB];
      RES_TUNE_ON          <= cfg7_reg[`TUNE_BIT];
      PLL_PHASE_INVERT     <= cfg7_reg[`PHASE_BIT];
      PLL_LOOP_OPEN        <= cfg7_reg[`LOOP_OPEN_BIT];
      ALU_AUTO             <= !QUIET;
      ALU_START            <= QUIET && (trig_rise || SOFT_TRIGGER);
    end
  end
endmodule
`default_nettype wire

// [dv/time_conv_monitor.sv]
// Purpose: port checks of the converter register bank
// Assumes: reset pins reach the reset outputs through three flops
// Notes: bound into time_conv_regs
`timescale 1ns/10ps
`default_nettype none
module time_conv_monitor (
  input wire logic        CLK, RESET, RD_N, QUIET, SOFT_TRIGGER, REF_TICK, ALU_TRIGGER,
  input wire logic        OUTPUT_ENABLE_PIN_N, DATA_OE, FULL_RESET, PART_RESET, ALU_START,
  input wire logic        ALU_AUTO, TIMER_END, RESULT_A_READY, RESULT_B_READY,
  input wire logic [1:0]  MODE,
  input wire logic [17:0] START_OFFSET_SECONDARY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_FULL_SRC: assert property (
    $rose(FULL_RESET) |-> $past(ALU_TRIGGER, 3) || !$past(OUTPUT_ENABLE_PIN_N, 3))
    else $error("full reset without cause");
  AST_PART_SRC: assert property (
    $rose(PART_RESET) |-> $past(ALU_TRIGGER, 3) || !$past(OUTPUT_ENABLE_PIN_N, 3))
    else $error("partial reset without cause");
  AST_SOFT_GO: assert property (QUIET && SOFT_TRIGGER |=> ALU_START)
    else $error("soft trigger lost");
  AST_AUTO: assert property (!$past(RESET) |-> ALU_AUTO == !$past(QUIET))
    else $error("auto start wrong");
  AST_TIMER: assert property (TIMER_END |-> $past(REF_TICK) || $past(REF_TICK, 2))
    else $error("timer end off tick");
  AST_FLUSH: assert property (
    FULL_RESET [*2] |-> RESULT_A_READY && RESULT_B_READY)
    else $error("queues not flushed");
  AST_OFS2: assert property (
    !$past(RESET) && $past(MODE) != 2'h1 |-> START_OFFSET_SECONDARY == 18'h00000)
    else $error("secondary offset outside G");
  AST_OE_DROP: assert property (RD_N [*5] |-> !DATA_OE)
    else $error("bus still driven");
endmodule
bind time_conv_regs time_conv_monitor MON (.*);
`default_nettype wire

// [dv/host_bus_model.sv]
// Purpose: host side of the strobed register bus
// Assumes: strobes move at falling edges
// Notes: released write data shows the inverse of the last word
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input  wire logic        CLK,
  input  wire logic [27:0] DATA_OUT,
  output logic             CS_N, RD_N, WR_N,
  output logic [3:0]       ADDR,
  output logic [27:0]      DATA_IN
);
  initial begin
    {CS_N, RD_N, WR_N} = 3'h7;
    ADDR = 4'h0;
    DATA_IN = 28'h0;
  end
  // held eight cycles so the synchroniser and read latency fit inside
  task automatic xfer(input logic w, input logic [3:0] a, input logic [27:0] d,
                      output logic [27:0] q);
    @(negedge CLK);
    ADDR = a;
    DATA_IN = d;
    {CS_N, RD_N, WR_N} = {1'h0, w, !w};
    repeat (8) @(posedge CLK);
    q = DATA_OUT;
    @(negedge CLK);
    {CS_N, RD_N, WR_N} = 3'h7;
    DATA_IN = ~d;
    repeat (5) @(negedge CLK);
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: directed tests of the converter register bank
// Assumes: default queue depth of two
// Notes: result streams and core status driven here
`include "time_conv_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CLK = 1'h0, RESET = 1'h1, OUTPUT_ENABLE_PIN_N = 1'h0, ALU_TRIGGER = 1'h0;
  logic START_PIN = 1'h0, QUIET = 1'h0, SOFT_TRIGGER = 1'h0, REF_TICK = 1'h0;
  logic TIMER_START = 1'h0, RESULT_A_VALID = 1'h0, RESULT_B_VALID = 1'h0;
  logic CS_N, RD_N, WR_N, DATA_OE, RESULT_A_READY, RESULT_B_READY, STOP_INPUTS_ENABLE;
  logic START_INPUT_ENABLE, FULL_RESET, PART_RESET, DIFF_ROUTING, DIFF_POWER, RES_TUNE_ON;
  logic PLL_PHASE_INVERT, PLL_LOOP_OPEN, TIMER_END, ALU_START, ALU_AUTO;
  logic [1:0] MODE = 2'h0, FILL_FLAG;
  logic [2:0] PLL_REF_DIV;
  logic [3:0] ADDR;
  logic [7:0] PLL_FAST_DIV;
  logic [16:0] START_INTERVAL = 17'h0ABCD;
  logic [17:0] START_OFFSET_PRIMARY, START_OFFSET_SECONDARY;
  logic [27:0] DATA_IN, DATA_OUT, q, ends = 28'h0;
  time_conv_pkg::hit_t RESULT_A_DATA = '0, RESULT_B_DATA = '0;
  int n_errors = 0, check_count = 0, cycles = 0;
  time_conv_regs DUT (.*);
  host_bus_model host (.CLK(CLK), .DATA_OUT(DATA_OUT), .CS_N(CS_N), .RD_N(RD_N),
                       .WR_N(WR_N), .ADDR(ADDR), .DATA_IN(DATA_IN));
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles = cycles + 1;
    if (TIMER_END === 1'h1) ends = ends + 28'h1;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [27:0] g, input logic [27:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e); chk({27'h0, g}, {27'h0, e}); endtask
  task automatic wr(input logic [3:0] a, input logic [27:0] d); host.xfer(1'h1, a, d, q); endtask
  task automatic rd(input logic [3:0] a, input logic [27:0] e);
    host.xfer(1'h0, a, 28'h0, q);
    chk(q, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge CLK);
    s = 1'h1;
    @(negedge CLK);
    s = 1'h0;
  endtask
  // ready is looked at while valid stands, so a full queue shows its refusal
  task automatic push(input logic b, input time_conv_pkg::hit_t h, input logic r);
    @(negedge CLK);
    {RESULT_A_DATA, RESULT_B_DATA} = {h, h};
    {RESULT_A_VALID, RESULT_B_VALID} = {!b, b};
    chkb(b ? RESULT_B_READY : RESULT_A_READY, r);
    @(negedge CLK);
    {RESULT_A_VALID, RESULT_B_VALID} = 2'h0;
  endtask
  initial begin
    repeat (10) @(negedge CLK);
    RESET = 1'h0;
    wr(`ADR_GATING, 28'h0012345);
    wr(`ADR_LEVEL, 28'hC123402);
    wr(`ADR_PLL, 28'h0011B5A);
    chk(28'(START_OFFSET_PRIMARY), 28'h0012345);
    chkb(DIFF_POWER, 1'h1);
    chkb(DIFF_ROUTING, 1'h1);
    chk({14'h0, PLL_LOOP_OPEN, PLL_PHASE_INVERT, RES_TUNE_ON, PLL_REF_DIV, PLL_FAST_DIV},
        28'h0001B5A);
    rd(`ADR_LEVEL, 28'hC1234FD);
    pulse(TIMER_START);
    repeat (2) pulse(REF_TICK);
    repeat (3) @(negedge CLK);
    chk(ends, 28'h0);
    pulse(REF_TICK);
    repeat (3) @(negedge CLK);
    chk(ends, 28'h1);
    $display("config test done");
    chk({26'h0, FILL_FLAG}, 28'h0);
    push(1'h0, 34'h23CFF0123, 1'h1);
    push(1'h0, 34'h101000456, 1'h1);
    push(1'h0, 34'h3FFAABCDE, 1'h0);
    chk({26'h0, FILL_FLAG}, 28'h1);
    rd(`ADR_RESULT_A, 28'h8F30123);
    rd(`ADR_RESULT_A, 28'h4040456);
    rd(`ADR_RESULT_A, 28'h0);
    rd(`ADR_INTERVAL, 28'h000ABCD);
    MODE = 2'h1;
    repeat (2) push(1'h1, 34'h3FFAABCDE, 1'h1);
    chk(28'(START_OFFSET_SECONDARY), 28'h0001234);
    chkb(DIFF_ROUTING, 1'h0);
    rd(`ADR_INTERVAL, 28'h0);
    rd(`ADR_RESULT_B, 28'h06ABCDE);
    MODE = 2'h2;
    rd(`ADR_RESULT_B, 28'h02ABCDE);
    $display("result test done");
    push(1'h0, 34'h101000456, 1'h1);
    wr(`ADR_GATING, 28'h0812345);
    ALU_TRIGGER = 1'h1;
    repeat (5) @(negedge CLK);
    chkb(FULL_RESET, 1'h1);
    ALU_TRIGGER = 1'h0;
    rd(`ADR_RESULT_A, 28'h0);
    push(1'h0, 34'h101000456, 1'h1);
    OUTPUT_ENABLE_PIN_N = 1'h1;
    wr(`ADR_GATING, 28'h4012345);
    OUTPUT_ENABLE_PIN_N = 1'h0;
    repeat (5) @(negedge CLK);
    chkb(PART_RESET, 1'h1);
    OUTPUT_ENABLE_PIN_N = 1'h1;
    wr(`ADR_GATING, 28'h0012345);
    OUTPUT_ENABLE_PIN_N = 1'h0;
    rd(`ADR_RESULT_A, 28'h0000456);
    chk(28'(START_OFFSET_PRIMARY), 28'h0012345);
    QUIET = 1'h1;
    pulse(SOFT_TRIGGER);
    chkb(ALU_AUTO, 1'h0);
    // no start has been seen since the partial reset, so the stop gate starts shut and the start gate open
    wr(`ADR_GATING, 28'h0612345);
    chkb(STOP_INPUTS_ENABLE, 1'h0);
    chkb(START_INPUT_ENABLE, 1'h1);
    pulse(START_PIN);
    repeat (3) @(negedge CLK);
    chkb(STOP_INPUTS_ENABLE, 1'h1);
    chkb(START_INPUT_ENABLE, 1'h0);
    MODE = 2'h0;
    repeat (2) @(negedge CLK);
    chkb(START_INPUT_ENABLE, 1'h1);
    $display("reset test done");
    wr(`ADR_BUS_WIDTH, 28'hFFFFFFF);
    rd(`ADR_BUS_WIDTH, 28'h0000010);
    rd(`ADR_BUS_WIDTH, 28'h0);
    rd(`ADR_PLL, 28'h0001B5A);
    rd(`ADR_PLL, 28'h0000001);
    repeat (2) wr(`ADR_BUS_WIDTH, 28'h0);
    rd(`ADR_PLL, 28'h0011B5A);
    $display("bus width test done");
    summarize();
  end
endmodule
`default_nettype wire
